/* hw/rcc_calib_ctrl.sv */
// Contract
// - Calibrate at the divide-by-256 stage only.
// - Magnitude is low five calibration bits.
// - Bit five picks faster or slower correction.
// - 64-minute cycle, 62 eligible, 256/128 cycles.
// - Magnitude N corrects the first 2N minutes.
// - Test bit, oscillator running: 512 Hz tone.
// - Tone ignores the calibration value.
// - Test bit clears on main power loss.
// - Battery mode releases the pin high.
// - Test bit clear: pin follows level bit.
// - Century flag toggles at rollover when enabled.
// - Fail flag sets on halt or stopped oscillator.
// - Fail flag clears only by software write.
// - First power-up defaults for four control bits.
// - Later power-up clears only the test bit.
// - Halt bit is seconds register bit seven.
// - Halt stops divider; clearing restarts it.
// - Fail flag is minutes register bit seven.
`default_nettype none
module rcc_calib_ctrl
  import rcc_pkg::*;
(
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire logic                      oscClkIn,
  input  wire logic                      mainPowerOk,
  input  wire logic                      oscStoppedIn,
  input  wire logic                      centuryRoll,
  input  wire logic                      regWrEn,
  input  wire logic [rcc_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [rcc_pkg::DATA_W-1:0] regWrData,
  output logic      [rcc_pkg::DATA_W-1:0] regRdData,
  output logic                           secondPulse,
  output logic                           freqCheckPinOut,
  output logic                           freqCheckPinOe
);
  // Synchronised external levels.
  logic [2:0] syncIn;
  logic       oscSync;    // Oscillator as seen on the system clock.
  logic       pwrSync;    // Main power good.
  logic       stopSync;   // Oscillator detector reports no oscillation.

  rcc_sync #(.WIDTH(3)) u_sync (
    .clock   (clock),
    .rst     (rst),
    .asyncIn ({oscClkIn, mainPowerOk, oscStoppedIn}),
    .syncOut (syncIn)
  );
  assign oscSync  = syncIn[2];
  assign pwrSync  = syncIn[1];
  assign stopSync = syncIn[0];

  // Control and status bits.
  logic       oscPrev_ff;   // Previous synchronised oscillator level.
  logic       halt_ff;      // Oscillator halt bit.
  logic       fail_ff;      // Oscillator fail flag.
  logic       centEn_ff;    // Century toggle enable.
  logic       centFlag_ff;  // Century flag.
  logic [7:0] calib_ff;     // Calibration and pin control register.
  logic [7:0] rdData_ff;    // Registered read answer.
  logic       nxt_oscPrev;
  logic       nxt_halt;
  logic       nxt_fail;
  logic       nxt_centEn;
  logic       nxt_centFlag;
  logic [7:0] nxt_calib;
  logic [7:0] nxt_rdData;

  // Divider chain state.
  logic [8:0] prescale_ff;  // Oscillator cycles inside a stage period.
  logic [6:0] stage_ff;     // Stage periods inside a second.
  logic [5:0] secInMin_ff;  // Seconds inside a minute.
  logic [5:0] minCyc_ff;    // Minutes inside the correction cycle.
  logic       secPulse_ff;
  logic [8:0] nxt_prescale;
  logic [6:0] nxt_stage;
  logic [5:0] nxt_secInMin;
  logic [5:0] nxt_minCyc;
  logic       nxt_secPulse;

  // Pin state.
  logic       pinOe_ff;
  logic       pinOut_ff;
  logic       nxt_pinOe;
  logic       nxt_pinOut;

  // Decoded strobes.
  logic       oscTick;      // One oscillator cycle while running.
  logic       wrSec;
  logic       wrMin;
  logic       wrCent;
  logic       wrCal;
  logic       adjustNow;    // This second is a corrected one.
  logic       adjustPos;
  logic       adjustNeg;
  logic [8:0] stageLast;
  logic [6:0] secLast;
  logic       stageEnd;
  logic       secEnd;
  logic       toneLevel;

  assign wrSec  = regWrEn && (regAddr == ADDR_SECONDS);
  assign wrMin  = regWrEn && (regAddr == ADDR_MINUTES);
  assign wrCent = regWrEn && (regAddr == ADDR_CENTURY);
  assign wrCal  = regWrEn && (regAddr == ADDR_CALIB);

  // A halted oscillator produces no ticks at all.
  assign oscTick = oscSync && !oscPrev_ff && !halt_ff;

  // Tone takes raw ticks, so calibration never reaches it.
  rcc_tone_gen u_tone (
    .clock     (clock),
    .rst       (rst),
    .tick      (oscTick),
    .toneLevel (toneLevel)
  );

  // The first second of each eligible minute is corrected.
  always_comb begin
    adjustNow = (secInMin_ff == 6'h00) &&
                (minCyc_ff < {calib_ff[MAG_MSB:0], 1'b0});
    adjustPos = adjustNow && calib_ff[SIGN_BIT];
    adjustNeg = adjustNow && !calib_ff[SIGN_BIT];
    // Slower: the first stage period gains 128 cycles.
    stageLast = (adjustNeg && stage_ff == 7'h00) ? STAGE_LAST_NEG
                                                 : STAGE_LAST;
    // Faster: one whole 256-cycle stage period is dropped.
    secLast   = adjustPos ? SEC_LAST_POS : SEC_LAST;
    // Comparing with >= recovers if the limits move under a running count.
    stageEnd  = oscTick && (prescale_ff >= stageLast);
    secEnd    = stageEnd && (stage_ff >= secLast);
  end

  // Divider chain next values.
  always_comb begin
    nxt_prescale = prescale_ff;
    nxt_stage    = stage_ff;
    nxt_secInMin = secInMin_ff;
    nxt_minCyc   = minCyc_ff;
    nxt_secPulse = secEnd;
    if (oscTick) begin
      nxt_prescale = stageEnd ? 9'h000 : prescale_ff + 9'h001;
    end
    if (stageEnd) begin
      nxt_stage = secEnd ? 7'h00 : stage_ff + 7'h01;
    end
    if (secEnd) begin
      if (secInMin_ff >= MIN_LAST) begin
        nxt_secInMin = 6'h00;
        // Wraps from the last minute back to the cycle start.
        nxt_minCyc = (minCyc_ff == CYCLE_LAST) ? 6'h00
                                               : minCyc_ff + 6'h01;
      end else begin
        nxt_secInMin = secInMin_ff + 6'h01;
      end
    end
  end

  // Register file next values.
  always_comb begin
    nxt_oscPrev  = oscSync;
    nxt_halt     = halt_ff;
    nxt_fail     = fail_ff;
    nxt_centEn   = centEn_ff;
    nxt_centFlag = centFlag_ff;
    nxt_calib    = calib_ff;
    if (wrSec) begin
      nxt_halt = regWrData[HALT_BIT];
    end
    if (wrMin) begin
      nxt_fail = regWrData[FAIL_BIT];
    end
    // Any stop condition sets the flag and beats a clearing write.
    if (halt_ff || stopSync) begin
      nxt_fail = 1'b1;
    end
    if (wrCent) begin
      nxt_centEn   = regWrData[CENT_EN];
      nxt_centFlag = regWrData[CENT_FLAG];
    end
    if (centuryRoll && nxt_centEn) begin
      nxt_centFlag = ~nxt_centFlag;
    end
    if (wrCal) begin
      nxt_calib = regWrData;
    end
    // Losing main power clears the test bit, whatever is written.
    if (!pwrSync) begin
      nxt_calib[FTEST_BIT] = 1'b0;
    end
    // Read answer, one cycle after the address.
    if (regAddr == ADDR_SECONDS) begin
      nxt_rdData = {halt_ff, 7'h00};
    end else if (regAddr == ADDR_MINUTES) begin
      nxt_rdData = {fail_ff, 7'h00};
    end else if (regAddr == ADDR_CENTURY) begin
      nxt_rdData = {centEn_ff, centFlag_ff, 6'h00};
    end else if (regAddr == ADDR_CALIB) begin
      nxt_rdData = calib_ff;
    end else begin
      nxt_rdData = 8'h00;
    end
  end

  // Open-drain pin: the data line is always low, only the enable moves.
  always_comb begin
    nxt_pinOut = 1'b0;
    if (!pwrSync) begin
      nxt_pinOe = 1'b0;
    end else if (calib_ff[FTEST_BIT]) begin
      // A halted oscillator freezes the tone at its last level.
      nxt_pinOe = !toneLevel;
    end else begin
      nxt_pinOe = !calib_ff[OUT_BIT];
    end
  end

  // All state registers; reset stands for the first power application.
  always_ff @(posedge clock) begin
    if (rst) begin
      oscPrev_ff  <= 1'b0;
      halt_ff     <= HALT_RST;
      fail_ff     <= FAIL_RST;
      centEn_ff   <= 1'b0;
      centFlag_ff <= 1'b0;
      calib_ff    <= {OUT_RST, FT_RST, CAL_RST};
      rdData_ff   <= 8'h00;
      prescale_ff <= 9'h000;
      stage_ff    <= 7'h00;
      secInMin_ff <= 6'h00;
      minCyc_ff   <= 6'h00;
      secPulse_ff <= 1'b0;
      pinOe_ff    <= 1'b0;
      pinOut_ff   <= 1'b0;
    end else begin
      oscPrev_ff  <= nxt_oscPrev;
      halt_ff     <= nxt_halt;
      fail_ff     <= nxt_fail;
      centEn_ff   <= nxt_centEn;
      centFlag_ff <= nxt_centFlag;
      calib_ff    <= nxt_calib;
      rdData_ff   <= nxt_rdData;
      prescale_ff <= nxt_prescale;
      stage_ff    <= nxt_stage;
      secInMin_ff <= nxt_secInMin;
      minCyc_ff   <= nxt_minCyc;
      secPulse_ff <= nxt_secPulse;
      pinOe_ff    <= nxt_pinOe;
      pinOut_ff   <= nxt_pinOut;
    end
  end

  assign regRdData       = rdData_ff;
  assign secondPulse     = secPulse_ff;
  assign freqCheckPinOut = pinOut_ff;
  assign freqCheckPinOe  = pinOe_ff;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  battery_pin_a: assert property (!pwrSync |=> !pinOe_ff)
    else $error("Pin driven while on battery.");
  ftest_clear_a: assert property (!pwrSync |=> !calib_ff[FTEST_BIT])
    else $error("Test bit survived a power loss.");
  fail_sticky_a: assert property (
    fail_ff && !(wrMin && !regWrData[FAIL_BIT]) |=> fail_ff)
    else $error("Fail flag cleared without a write.");
  halt_fail_a: assert property (halt_ff || stopSync |=> fail_ff)
    else $error("Halt or a stop did not set the fail flag.");
  level_pin_a: assert property (
    pwrSync && !calib_ff[FTEST_BIT] |=>
      pinOe_ff == !$past(calib_ff[OUT_BIT]))
    else $error("Pin does not follow the level bit.");
  tone_pin_a: assert property (
    pwrSync && calib_ff[FTEST_BIT] |=> pinOe_ff == !$past(toneLevel))
    else $error("Pin does not follow the test tone.");
  zero_cal_a: assert property (
    calib_ff[MAG_MSB:0] == 5'h00 |-> !adjustNow)
    else $error("Correction with zero magnitude.");
  cycle_window_a: assert property (
    adjustNow |-> minCyc_ff < (CYCLE_LAST - 6'h01))
    else $error("Correction outside the eligible minutes.");
  century_flip_a: assert property (
    centuryRoll && centEn_ff && !wrCent |=> centFlag_ff != $past(centFlag_ff))
    else $error("Century flag did not toggle.");
  halt_freeze_a: assert property (
    halt_ff |=> prescale_ff == $past(prescale_ff))
    else $error("Divider ran while halted.");
  pin_drive_a: assert property (freqCheckPinOut == 1'b0)
    else $error("Open-drain pin driven high.");
endmodule : rcc_calib_ctrl
`default_nettype wire

/* hw/rcc_pkg.sv */
`default_nettype none
// Shared constants for the calibration and pin control block.
package rcc_pkg;
  // Register bus geometry.
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register addresses.
  localparam logic [2:0] ADDR_SECONDS = 3'h0;
  localparam logic [2:0] ADDR_MINUTES = 3'h1;
  localparam logic [2:0] ADDR_CENTURY = 3'h2;
  localparam logic [2:0] ADDR_CALIB   = 3'h7;

  // Field positions.
  localparam int unsigned HALT_BIT   = 7;  // Seconds register.
  localparam int unsigned FAIL_BIT   = 7;  // Minutes register.
  localparam int unsigned CENT_EN    = 7;  // Century/hours register.
  localparam int unsigned CENT_FLAG  = 6;  // Century/hours register.
  localparam int unsigned OUT_BIT    = 7;  // Calibration register.
  localparam int unsigned FTEST_BIT  = 6;  // Calibration register.
  localparam int unsigned SIGN_BIT   = 5;  // Calibration register.
  localparam int unsigned MAG_MSB    = 4;  // Calibration magnitude top.

  // Reset values after the first power application.
  localparam logic       HALT_RST = 1'b0;
  localparam logic       FAIL_RST = 1'b1;
  localparam logic       OUT_RST  = 1'b1;
  localparam logic       FT_RST   = 1'b0;
  localparam logic [5:0] CAL_RST  = 6'h00;

  // Divider chain counts, in oscillator cycles or stage periods.
  localparam int unsigned OSC_HZ      = 32768;
  localparam int unsigned TONE_HZ     = 512;
  localparam int unsigned TONE_HALF   = OSC_HZ / (2 * TONE_HZ);
  localparam int unsigned STAGE_DIV   = 256;
  localparam int unsigned NEG_STRETCH = 128;
  localparam int unsigned STAGES_SEC  = OSC_HZ / STAGE_DIV;
  localparam int unsigned SEC_PER_MIN = 60;
  localparam int unsigned CYCLE_MINS  = 64;

  localparam logic [8:0] STAGE_LAST     = 9'(STAGE_DIV - 1);
  localparam logic [8:0] STAGE_LAST_NEG = 9'(STAGE_DIV + NEG_STRETCH - 1);
  localparam logic [6:0] SEC_LAST       = 7'(STAGES_SEC - 1);
  localparam logic [6:0] SEC_LAST_POS   = 7'(STAGES_SEC - 2);
  localparam logic [5:0] MIN_LAST       = 6'(SEC_PER_MIN - 1);
  localparam logic [5:0] CYCLE_LAST     = 6'(CYCLE_MINS - 1);
  localparam logic [4:0] TONE_LAST      = 5'(TONE_HALF - 1);
endpackage : rcc_pkg
`default_nettype wire

/* hw/rcc_sync.sv */
`default_nettype none
// Two flip-flop synchroniser for levels from outside the clock domain.
module rcc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_ff;  // Only the second stage reads this.
  logic [WIDTH-1:0] stage2_ff;  // Settled copy.
  logic [WIDTH-1:0] nxt_stage1;
  logic [WIDTH-1:0] nxt_stage2;

  // Next values are plain shifts.
  always_comb begin
    nxt_stage1 = asyncIn;
    nxt_stage2 = stage1_ff;
  end

  // Both stages clear under reset.
  always_ff @(posedge clock) begin
    if (rst) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;
endmodule : rcc_sync
`default_nettype wire

/* hw/rcc_tone_gen.sv */
`default_nettype none
// Test tone divider, fed by raw oscillator ticks only.
module rcc_tone_gen
  import rcc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic tick,
  output logic      toneLevel
);
  logic [4:0] count_ff;   // Oscillator cycles within a half period.
  logic       level_ff;   // Current tone level.
  logic [4:0] nxt_count;
  logic       nxt_level;

  // The level flips every half period of the test tone.
  always_comb begin
    nxt_count = count_ff;
    nxt_level = level_ff;
    if (tick) begin
      if (count_ff == TONE_LAST) begin
        nxt_count = 5'h0;
        nxt_level = ~level_ff;
      end else begin
        nxt_count = count_ff + 5'h1;
      end
    end
  end

  // Registered state.
  always_ff @(posedge clock) begin
    if (rst) begin
      count_ff <= 5'h0;
      level_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      level_ff <= nxt_level;
    end
  end

  assign toneLevel = level_ff;
endmodule : rcc_tone_gen
`default_nettype wire

/* tb/rcc_osc_model.sv */
`default_nettype none
// Crystal stand-in: a free-running square wave that rests low while dead.
module rcc_osc_model #(
  parameter int unsigned HALF_NS = 80
) (
  input  wire logic running,
  output var  logic oscClk
);
  timeunit 1ns;
  timeprecision 1ps;

  // The odd start offset keeps the wave unrelated in phase to the clock.
  initial begin
    oscClk = 1'b0;
    #7;
    forever begin
      #(HALF_NS);
      // A stopped crystal gives no edges, so the line cannot fake activity.
      if (running) begin
        oscClk = ~oscClk;
      end else begin
        oscClk = 1'b0;
      end
    end
  end
endmodule : rcc_osc_model
`default_nettype wire

/* tb/testbench.sv */
`default_nettype none
// Self-checking bench for the calibration and pin control block.
module testbench
  import rcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock, rst, oscClkIn, mainPowerOk, oscStoppedIn;
  logic        centuryRoll, regWrEn, secondPulse;
  logic        freqCheckPinOut, freqCheckPinOe, last;
  logic [2:0]  regAddr;
  logic [7:0]  regWrData, regRdData, cal;
  logic [31:0] seed = 32'h0000_005C;
  int          errors = 0;
  int          total_checks = 0;
  int          pulses = 0;
  int          changes;
  // The pull-up makes a released pin read high.
  wire logic   pinLevel = freqCheckPinOe ? freqCheckPinOut : 1'b1;

  rcc_calib_ctrl DUT (.clock(clock), .rst(rst), .oscClkIn(oscClkIn),
    .mainPowerOk(mainPowerOk), .oscStoppedIn(oscStoppedIn),
    .centuryRoll(centuryRoll), .regWrEn(regWrEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .secondPulse(secondPulse), .freqCheckPinOut(freqCheckPinOut),
    .freqCheckPinOe(freqCheckPinOe));
  rcc_osc_model oscModel (.running(~oscStoppedIn), .oscClk(oscClkIn));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // The run is far shorter than one second, so any pulse is premature.
  // Sampling on the falling edge, out of reset, keeps the unknown value
  // that the output holds before the first reset edge out of the count.
  always @(negedge clock) if (!rst && secondPulse !== 1'b0) pulses++;

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : next_rand

  // Static pin level; battery mode always releases the pin.
  function automatic logic static_pin(input logic [7:0] c, input logic p);
    return p ? c[OUT_BIT] : 1'b1;
  endfunction : static_pin

  task automatic end_sim();
    if (errors == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim

  task automatic check(input string n, input logic [7:0] e, logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clock);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [2:0] a, logic [7:0] e);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    check(n, e, regRdData);
  endtask : rd

  task automatic pin(input string n, input logic e);
    cyc(6);
    check(n, {7'h0, e}, {7'h0, pinLevel});
  endtask : pin

  task automatic roll();
    @(negedge clock);
    centuryRoll = 1'b1;
    @(negedge clock);
    centuryRoll = 1'b0;
  endtask : roll

  // Half period of the tone must be 32 oscillator edges, 256 clocks.
  task automatic tone(input string n);
    int k;
    cyc(4);
    for (int j = 0; j < 2; j++) begin
      last = pinLevel;
      k = 0;
      while (pinLevel === last && k < 1000) begin
        @(negedge clock);
        k++;
      end
    end
    check(n, 8'h01, {7'h0, k >= 252 && k <= 260});
  endtask : tone

  initial begin
    rst = 1'b1;
    mainPowerOk = 1'b1;
    oscStoppedIn = 1'b0;
    centuryRoll = 1'b0;
    regWrEn = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    cyc(8);
    rst = 1'b0;
    rd("seconds", ADDR_SECONDS, 8'h00);
    rd("minutes", ADDR_MINUTES, 8'h80);
    rd("calib", ADDR_CALIB, 8'h80);
    pin("pin reset", 1'b1);
    wr(3'h4, 8'hFF);
    rd("unmapped", 3'h4, 8'h00);
    for (int i = 0; i < 6; i++) begin
      seed = next_rand(seed);
      cal = seed[7:0] & 8'hBF;
      wr(ADDR_CALIB, cal);
      rd("calib rd", ADDR_CALIB, cal);
      pin("pin level", static_pin(cal, 1'b1));
    end
    wr(ADDR_CALIB, 8'h40);
    tone("tone plain");
    wr(ADDR_CALIB, 8'hFF);
    tone("tone fast");
    wr(ADDR_CALIB, 8'h5F);
    tone("tone slow");
    // The four-second wait is cut short here to keep the run brief.
    wr(ADDR_MINUTES, 8'h00);
    rd("fail clr", ADDR_MINUTES, 8'h00);
    wr(ADDR_SECONDS, 8'h80);
    rd("halt rd", ADDR_SECONDS, 8'h80);
    rd("fail halt", ADDR_MINUTES, 8'h80);
    last = pinLevel;
    changes = 0;
    repeat (600) begin
      @(negedge clock);
      if (pinLevel !== last) changes++;
      last = pinLevel;
    end
    check("tone frozen", 8'h00, 8'(changes));
    wr(ADDR_MINUTES, 8'h00);
    rd("fail held", ADDR_MINUTES, 8'h80);
    wr(ADDR_SECONDS, 8'h00);
    tone("tone restart");
    wr(ADDR_MINUTES, 8'h00);
    cyc(600);
    rd("fail stays", ADDR_MINUTES, 8'h00);
    oscStoppedIn = 1'b1;
    cyc(8);
    oscStoppedIn = 1'b0;
    cyc(600);
    rd("fail stop", ADDR_MINUTES, 8'h80);
    wr(ADDR_CALIB, 8'h40);
    mainPowerOk = 1'b0;
    pin("pin battery", 1'b1);
    rd("ft cleared", ADDR_CALIB, 8'h00);
    wr(ADDR_CALIB, 8'h40);
    rd("ft refused", ADDR_CALIB, 8'h00);
    pin("pin bat low", static_pin(8'h00, 1'b0));
    mainPowerOk = 1'b1;
    pin("pin back", static_pin(8'h00, 1'b1));
    rd("halt kept", ADDR_SECONDS, 8'h00);
    rd("fail kept", ADDR_MINUTES, 8'h80);
    wr(ADDR_CENTURY, 8'hBF);
    roll();
    rd("cent on", ADDR_CENTURY, 8'hC0);
    roll();
    rd("cent back", ADDR_CENTURY, 8'h80);
    wr(ADDR_CENTURY, 8'h40);
    roll();
    rd("cent hold", ADDR_CENTURY, 8'h40);
    check("sec pulses", 8'h00, 8'(pulses));
    end_sim();
  end

  // Hang guard, well beyond the few thousand cycles the tests need.
  initial begin
    repeat (90000) @(posedge clock);
    errors++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
